// *** design/scm_top.sv ***
// Behaviour
// - Fast select high gives undivided fast clock; low uses divider select.
// - Divider 000/001 low-speed, 010../64 up to 111../2.
// - Fast and slow sources are fixed by configuration straps.
// - Normal mode: CPU on fast clock, undivided or divided, slow clocks all running.
// - Slow mode stops fast oscillator and its divided peripheral clocks.
// - Halt enters idle when idle select is one, else sleep.
// - Deep halt stops CPU and every clock, watchdog disabled.
// - Deep halt is never entered while voltage detect is enabled.
// - Halt keep slow: CPU, timebase stop; slow clocks kept if needed.
// - Idle with keep low stops system oscillator and CPU.
// - Idle with keep high stops CPU, system clock keeps running.
// - Fast wake with fast crystal runs on low-speed clock meanwhile.
// - Low ready flag low in deep halt; settles 128 or 2 cycles.
// - High ready flag clear at reset, set once fast oscillator stable.
// - High ready low in sleep, idle-stopped; 512 or 16 cycles.
`timescale 1ns/1ps
`default_nettype none
module scm_top (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        fast_osc_pin,
  input  wire logic        slow_osc_pin,
  input  wire logic        cfg_fast_is_xtal,
  input  wire logic        cfg_slow_is_xtal,
  input  wire logic        cfg_wdt_on_sub,
  input  wire logic        watchdog_enable,
  input  wire logic        voltage_detect_enable,
  input  wire logic        cpu_halt,
  input  wire logic        wake_event,
  output logic             system_clock,
  output logic             cpu_run,
  output logic             low_speed_run,
  output logic             watchdog_clk_run,
  output logic             timebase_run,
  output logic             fast_osc_enable,
  output logic             fast_div_avail,
  output logic             watchdog_disable,
  output logic             irq
);
  import scm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  scm_state_t state_r;
  scm_state_t state_nxt;
  logic [7:0] smc_r;
  logic       keep_r;
  logic [3:0] stat_r;
  logic [3:0] mask_r;
  logic [3:0] ev;
  logic [1:0] osc_sync;
  logic       fast_d_r;
  logic       slow_d_r;
  logic [9:0] hcnt_r;
  logic [7:0] lcnt_r;
  logic       hrdy_r;
  logic       lrdy_r;
  logic       temp_sub_r;
  logic       halt_ok;
  logic       slow_sel;
  logic       keep_slow;
  logic       fast_run;
  logic       sub_run;
  logic       sys_gate;
  logic       cpu_go;
  logic [2:0] src_sel;
  logic [2:0] act_sel;
  logic       wb_req;
  logic       wr_en;
  logic       fast_rise;
  logic       slow_rise;
  logic       fast_strap;
  logic       slow_strap;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator pins enter through three-stage synchronisers

  scm_sync3 u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({slow_osc_pin, fast_osc_pin}),
    .sync_out (osc_sync)
  );

  // Configuration straps are sampled after reset release
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fast_strap <= 1'b0;
      slow_strap <= 1'b0;
    end else begin
      fast_strap <= cfg_fast_is_xtal;
      slow_strap <= cfg_slow_is_xtal;
    end
  end

  // Oscillator edge detection
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fast_d_r <= 1'b0;
      slow_d_r <= 1'b0;
    end else begin
      fast_d_r <= osc_sync[0];
      slow_d_r <= osc_sync[1];
    end
  end

  always_comb begin
    fast_rise = osc_sync[0] && !fast_d_r;
    slow_rise = osc_sync[1] && !slow_d_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  always_comb begin
    slow_sel  = !smc_r[FAST_SEL_B] && (smc_r[7:6] == 2'h0);
    keep_slow = voltage_detect_enable ||
                (watchdog_enable && cfg_wdt_on_sub);
    fast_run  = (state_r == ST_NORMAL) ||
                (state_r == ST_IDLE_CLOCK_KEPT_MODE && !slow_sel);
    sub_run   = !(state_r == ST_DEEP_HALT_MODE) &&
                !(state_r == ST_HALT_KEEP_SLOW_MODE && !keep_slow);
    cpu_go    = (state_r == ST_NORMAL &&
                 (hrdy_r || (temp_sub_r && lrdy_r))) ||
                (state_r == ST_SLOW && lrdy_r);
    sys_gate  = cpu_go || state_r == ST_IDLE_CLOCK_KEPT_MODE;
    halt_ok   = cpu_halt && cpu_go;
    src_sel   = temp_sub_r ? SRC_SUB :
                scm_src(smc_r[FAST_SEL_B],
                        smc_r[7:DIV_SEL_LSB]);
  end

  // Next operating mode
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_NORMAL, ST_SLOW: begin
        if (halt_ok) begin
          if (smc_r[IDLE_SEL_B])
            state_nxt = keep_r ? ST_IDLE_CLOCK_KEPT_MODE : ST_IDLE_ALL_STOPPED_MODE;
          else if (keep_slow)
            state_nxt = ST_HALT_KEEP_SLOW_MODE;
          else
            state_nxt = ST_DEEP_HALT_MODE;
        end else begin
          state_nxt = slow_sel ? ST_SLOW : ST_NORMAL;
        end
      end
      ST_IDLE_ALL_STOPPED_MODE, ST_IDLE_CLOCK_KEPT_MODE, ST_DEEP_HALT_MODE, ST_HALT_KEEP_SLOW_MODE: begin
        if (wake_event)
          state_nxt = slow_sel ? ST_SLOW : ST_NORMAL;
      end
      default: state_nxt = ST_NORMAL;
    endcase
  end

  // Mode register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      state_r <= ST_NORMAL;
    else
      state_r <= state_nxt;
  end

  // Temporary low-speed clock after a fast wake-up
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      temp_sub_r <= 1'b0;
    else if (wake_event && state_nxt == ST_NORMAL &&
             (state_r == ST_HALT_KEEP_SLOW_MODE || state_r == ST_IDLE_ALL_STOPPED_MODE) &&
             smc_r[FAST_WAKE_B] && fast_strap && sub_run)
      temp_sub_r <= 1'b1;
    else if (hrdy_r || state_r != ST_NORMAL)
      temp_sub_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator ready flags

  // High-speed settle counter, held clear while the oscillator is off
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hcnt_r <= 10'h000;
      hrdy_r <= 1'b0;
    end else if (!fast_run) begin
      hcnt_r <= 10'h000;
      hrdy_r <= 1'b0;
    end else if (!hrdy_r && fast_rise) begin
      hcnt_r <= hcnt_r + 10'h001;
      if (hcnt_r + 10'h001 ==
          (fast_strap ? HXT_SETTLE : INTERNAL_FAST_RC_SETTLE))
        hrdy_r <= 1'b1;
    end
  end

  // Low-speed settle counter
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lcnt_r <= 8'h00;
      lrdy_r <= 1'b0;
    end else if (!sub_run) begin
      lcnt_r <= 8'h00;
      lrdy_r <= 1'b0;
    end else if (!lrdy_r && slow_rise) begin
      lcnt_r <= lcnt_r + 8'h01;
      if (lcnt_r + 8'h01 ==
          (slow_strap ? LXT_SETTLE : INTERNAL_SLOW_RC_SETTLE))
        lrdy_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock switch

  scm_clk_switch u_switch (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .fast_lvl (osc_sync[0] && fast_run),
    .sub_lvl  (osc_sync[1] && sub_run),
    .sel      (src_sel),
    .gate_en  (sys_gate),
    .act_sel  (act_sel),
    .clk_out  (system_clock)
  );

  // Clock enables seen by CPU and peripherals
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_run          <= 1'b0;
      low_speed_run    <= 1'b0;
      watchdog_clk_run <= 1'b0;
      timebase_run     <= 1'b0;
      fast_osc_enable  <= 1'b0;
      fast_div_avail   <= 1'b0;
      watchdog_disable <= 1'b0;
    end else begin
      cpu_run          <= cpu_go;
      low_speed_run    <= sub_run;
      watchdog_clk_run <= sub_run;
      timebase_run     <= state_r != ST_DEEP_HALT_MODE &&
                          state_r != ST_HALT_KEEP_SLOW_MODE;
      fast_osc_enable  <= fast_run;
      fast_div_avail   <= fast_run && hrdy_r;
      watchdog_disable <= state_r == ST_DEEP_HALT_MODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the strobe, one cycle wide

  always_comb begin
    wb_req = wb_cyc_i && wb_stb_i;
    wr_en  = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
    ev     = '0;
    ev[EV_HRDY] = fast_run && !hrdy_r && fast_rise &&
                  (hcnt_r + 10'h001 ==
                   (fast_strap ? HXT_SETTLE : INTERNAL_FAST_RC_SETTLE));
    ev[EV_LRDY] = sub_run && !lrdy_r && slow_rise &&
                  (lcnt_r + 8'h01 ==
                   (slow_strap ? LXT_SETTLE : INTERNAL_SLOW_RC_SETTLE));
    ev[EV_WAKE] = wake_event && !(state_r == ST_NORMAL ||
                                  state_r == ST_SLOW);
    ev[EV_HALT] = halt_ok;
  end

  // Acknowledge and read data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o) begin
        unique case (wb_adr_i)
          SMC_OFF: begin
            wb_dat_o <= {24'h000000, smc_r[7:4], lrdy_r, hrdy_r,
                         smc_r[1:0]};
          end
          CTRL_OFF: wb_dat_o <= {31'h0, keep_r};
          STAT_OFF: wb_dat_o <= {28'h0, stat_r};
          MASK_OFF: wb_dat_o <= {28'h0, mask_r};
          MODE_OFF: wb_dat_o <= {26'h0, state_r};
          default:  wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writable control registers, written at the acknowledging edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      smc_r  <= SMC_RST;
      keep_r <= KEEP_RST;
      mask_r <= MASK_RST;
    end else if (wr_en) begin
      if (wb_adr_i == SMC_OFF)
        smc_r <= wb_dat_i[7:0] & 8'hf3;
      if (wb_adr_i == CTRL_OFF)
        keep_r <= wb_dat_i[KEEP_B];
      if (wb_adr_i == MASK_OFF)
        mask_r <= wb_dat_i[3:0];
    end
  end

  // Sticky event bits: write one clears, a new event wins
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      stat_r <= 4'h0;
    else if (wr_en && wb_adr_i == STAT_OFF)
      stat_r <= (stat_r & ~wb_dat_i[3:0]) | ev;
    else
      stat_r <= stat_r | ev;
  end

  // Level interrupt
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(stat_r & mask_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence halt_taken;
    halt_ok && (state_r == ST_NORMAL || state_r == ST_SLOW);
  endsequence

  chk_halt_sleep: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    halt_taken ##0 !smc_r[IDLE_SEL_B] |=>
      (state_r == ST_DEEP_HALT_MODE || state_r == ST_HALT_KEEP_SLOW_MODE))
    else $error("Halt with idle select low did not sleep");

  chk_no_deep_lvd: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    halt_taken ##0 voltage_detect_enable |=> state_r != ST_DEEP_HALT_MODE)
    else $error("Deep halt entered with voltage detect on");

  chk_idle_stop: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    halt_taken ##0 smc_r[IDLE_SEL_B] && !keep_r |=>
      state_r == ST_IDLE_ALL_STOPPED_MODE ##1 !fast_osc_enable && low_speed_run)
    else $error("Idle-stopped mode entry wrong");

  chk_idle_keep: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    halt_taken ##0 smc_r[IDLE_SEL_B] && keep_r |=>
      state_r == ST_IDLE_CLOCK_KEPT_MODE ##1 !cpu_run)
    else $error("Idle-kept mode entry wrong");

  chk_deep_clocks: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_r == ST_DEEP_HALT_MODE |=> watchdog_disable && !low_speed_run &&
      !timebase_run && !cpu_run && !lrdy_r)
    else $error("Deep halt left a clock running");

  chk_hrdy_low: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_DEEP_HALT_MODE || state_r == ST_HALT_KEEP_SLOW_MODE ||
     state_r == ST_IDLE_ALL_STOPPED_MODE) |=> !hrdy_r)
    else $error("High ready set while oscillator stopped");

  chk_slow_nofast: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state_r == ST_SLOW [*2] |-> !fast_div_avail && !fast_osc_enable)
    else $error("Fast clocks offered in slow mode");

  chk_sel_decode: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !temp_sub_r && smc_r[FAST_SEL_B] |-> src_sel == SRC_FAST)
    else $error("Fast select did not pick fast clock");

  chk_fast_wake: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    temp_sub_r && !hrdy_r |-> src_sel == SRC_SUB)
    else $error("Fast wake did not use low-speed clock");

  chk_hrdy_count: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(hrdy_r) |-> hcnt_r == (fast_strap ? HXT_SETTLE : INTERNAL_FAST_RC_SETTLE))
    else $error("High ready rose at wrong count");

endmodule
`default_nettype wire

// *** design/scm_pkg.sv ***
package scm_pkg;

  // Register byte offsets
  localparam logic [7:0] SMC_OFF      = 8'h00;
  localparam logic [7:0] CTRL_OFF     = 8'h04;
  localparam logic [7:0] STAT_OFF     = 8'h08;
  localparam logic [7:0] MASK_OFF     = 8'h0c;
  localparam logic [7:0] MODE_OFF     = 8'h10;

  // Field positions of system_mode_control, and of the keep bit in the control register
  localparam int DIV_SEL_LSB  = 5;
  localparam int FAST_WAKE_B  = 4;
  localparam int LOW_RDY_B    = 3;
  localparam int HIGH_RDY_B   = 2;
  localparam int IDLE_SEL_B   = 1;
  localparam int FAST_SEL_B   = 0;
  localparam int KEEP_B       = 0;

  // Reset values
  localparam logic [7:0] SMC_RST      = 8'h03;
  localparam logic       KEEP_RST     = 1'b0;
  localparam logic [3:0] MASK_RST     = 4'h0;

  // Event bits of the status and mask registers
  localparam int EV_HRDY      = 0;
  localparam int EV_LRDY      = 1;
  localparam int EV_WAKE      = 2;
  localparam int EV_HALT      = 3;

  // Oscillator settle counts, in oscillator cycles
  localparam logic [9:0] HXT_SETTLE   = 10'h200;
  localparam logic [9:0] INTERNAL_FAST_RC_SETTLE  = 10'h010;
  localparam logic [7:0] LXT_SETTLE   = 8'h80;
  localparam logic [7:0] INTERNAL_SLOW_RC_SETTLE  = 8'h02;

  // Clock switch source indices
  localparam logic [2:0] SRC_FAST     = 3'h0;
  localparam logic [2:0] SRC_SUB      = 3'h7;
  localparam logic [3:0] DIV_BASE     = 4'h8;

  // Operating modes
  typedef enum logic [5:0] {
    ST_NORMAL = 6'h01,
    ST_SLOW   = 6'h02,
    ST_IDLE_ALL_STOPPED_MODE  = 6'h04,
    ST_IDLE_CLOCK_KEPT_MODE  = 6'h08,
    ST_DEEP_HALT_MODE = 6'h10,
    ST_HALT_KEEP_SLOW_MODE = 6'h20
  } scm_state_t;

  // Maps register selection to a switch source index
  function automatic logic [2:0] scm_src(input logic fsel,
                                         input logic [2:0] dsel);
    if (fsel)
      return SRC_FAST;
    else if (dsel[2:1] == 2'h0)
      return SRC_SUB;
    else
      return 3'(DIV_BASE - {1'b0, dsel});
  endfunction

endpackage

// *** design/scm_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none
module scm_sync3 (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);
  import scm_pkg::*;

  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;

  // Three stages; output moves once the last two agree
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r     <= 2'h0;
      s2_r     <= 2'h0;
      s3_r     <= 2'h0;
      sync_out <= 2'h0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 2; i++) begin
        if (s2_r[i] == s3_r[i])
          sync_out[i] <= s3_r[i];
      end
    end
  end

endmodule
`default_nettype wire

// *** design/scm_clk_switch.sv ***
`timescale 1ns/1ps
`default_nettype none
module scm_clk_switch (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       fast_lvl,
  input  wire logic       sub_lvl,
  input  wire logic [2:0] sel,
  input  wire logic       gate_en,
  output logic      [2:0] act_sel,
  output logic            clk_out
);
  import scm_pkg::*;

  logic [5:0] div_r;
  logic       fast_d_r;
  logic       gate_r;
  logic [7:0] lvl;

  // Candidate levels: fast, fast/2 .. fast/64, low-speed
  always_comb begin
    lvl = {sub_lvl, div_r, fast_lvl};
  end

  // Ripple divider advanced on each fast rising edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r    <= 6'h00;
      fast_d_r <= 1'b0;
    end else begin
      fast_d_r <= fast_lvl;
      if (fast_lvl && !fast_d_r)
        div_r <= div_r + 6'h01;
    end
  end

  // Source changes only while old and new levels are low, gate only while the active level is low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_sel <= SRC_FAST;
      gate_r  <= 1'b0;
      clk_out <= 1'b0;
    end else begin
      if (!lvl[act_sel] && !lvl[sel])
        act_sel <= sel;
      if (!lvl[act_sel])
        gate_r <= gate_en;
      clk_out <= gate_r && lvl[act_sel];
    end
  end

  chk_switch_low: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (act_sel != $past(act_sel)) |-> !$past(clk_out) || !clk_out)
    else $error("Clock source switched while output high");

endmodule
`default_nettype wire

// *** dv/scm_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// CPU core and oscillator sources seen from the clock controller
module scm_cpu_model (
  input  wire logic core_clk,
  input  wire logic cpu_run,
  output logic      cpu_halt,
  output logic      wake_event,
  output logic      fast_osc_pin,
  output logic      slow_osc_pin
);
  ////////////////////////////////////////////////////////////////////////////
  // Free running oscillators, phase unrelated to the core clock
  initial begin
    cpu_halt     = 1'b0;
    wake_event   = 1'b0;
    fast_osc_pin = 1'b0;
    slow_osc_pin = 1'b0;
    fork
      forever #100 fast_osc_pin = ~fast_osc_pin;
      forever #170 slow_osc_pin = ~slow_osc_pin;
    join
  end

  ////////////////////////////////////////////////////////////////////////////
  // Halt is issued once the CPU runs or after 400 cycles, as one-cycle pulse
  task automatic do_halt();
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
    cpu_halt <= 1'b1;
    @(posedge core_clk);
    cpu_halt <= 1'b0;
  endtask

  // Wake source pulse
  task automatic do_wake();
    @(posedge core_clk);
    wake_event <= 1'b1;
    @(posedge core_clk);
    wake_event <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  import scm_pkg::*;
  logic        core_clk, sys_rst, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic        cfg_fast, cfg_slow, cfg_wdt, wdt_en, vde;
  logic        fpin, spin, halt, wake, sysclk, cpu_run, lsr, wcr, tbr;
  logic        foe, fda, wdd, irq;
  int          fail_count, tests_run, k;
  logic [5:0]  row [4];

  scm_top i_scm_top (.core_clk(core_clk), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fast_osc_pin(fpin), .slow_osc_pin(spin), .cfg_fast_is_xtal(cfg_fast),
    .cfg_slow_is_xtal(cfg_slow), .cfg_wdt_on_sub(cfg_wdt),
    .watchdog_enable(wdt_en), .voltage_detect_enable(vde),
    .cpu_halt(halt), .wake_event(wake), .system_clock(sysclk),
    .cpu_run(cpu_run), .low_speed_run(lsr), .watchdog_clk_run(wcr),
    .timebase_run(tbr), .fast_osc_enable(foe), .fast_div_avail(fda),
    .watchdog_disable(wdd), .irq(irq));

  scm_cpu_model i_scm_cpu_model (.core_clk(core_clk), .cpu_run(cpu_run),
    .cpu_halt(halt), .wake_event(wake), .fast_osc_pin(fpin),
    .slow_osc_pin(spin));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and watchdog against hangs
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end

  // Classic single Wishbone cycle, released at the edge that sees ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a;
    wdat <= {24'h000000, d}; sel <= 4'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Poll until the fast oscillator is ready and the CPU runs
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      bus(1'b0, SMC_OFF, 8'h00);
      n++;
    end while ((q[2] !== 1'b1 || cpu_run !== 1'b1) && n < 3000);
    if (n >= 3000) fail_count++;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    fail_count = 0; tests_run = 0;
    cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0; sys_rst = 1'b1;
    cfg_fast = 0; cfg_slow = 0; cfg_wdt = 1; wdt_en = 0; vde = 0;
    // idle, keep, vde, lsr, timebase, deep_halt_mode
    row = '{6'b100110, 6'b110110, 6'b000001, 6'b001100};
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus(1'b0, SMC_OFF, 8'h00);
    `CHK("smc_rst", 8'h03, q[7:0] & 8'hf3)
    `CHK("hrdy_rst", 1'b0, q[2])
    bus(1'b0, MODE_OFF, 8'h00);
    `CHK("mode_rst", 8'h01, q[7:0])
    wait_ready();
    `CHK("hrdy_set", 1'b1, q[2])
    bus(1'b0, STAT_OFF, 8'h00);
    `CHK("stat_hrdy", 1'b1, q[EV_HRDY])
    `CHK("irq_masked", 1'b0, irq)
    bus(1'b1, MASK_OFF, 8'h01);
    repeat (3) @(posedge core_clk);
    `CHK("irq_on", 1'b1, irq)
    bus(1'b1, STAT_OFF, 8'h01);
    repeat (3) @(posedge core_clk);
    `CHK("irq_off", 1'b0, irq)
    k = 0;
    repeat (40) begin
      @(posedge core_clk);
      k += sysclk;
    end
    `CHK("sysclk_run", 1'b1, k > 0)
    bus(1'b1, 8'h1c, 8'hff);
    bus(1'b0, 8'h1c, 8'h00);
    `CHK("unmapped", 32'h0, q)
    $display("test registers done");
    // Every divider code with the fast select low
    for (int d = 0; d < 8; d++) begin
      bus(1'b1, SMC_OFF, {d[2:0], 5'h02});
      repeat (4) @(posedge core_clk);
      if (d >= 2) wait_ready();
      bus(1'b0, MODE_OFF, 8'h00);
      `CHK("div_mode", (d < 2) ? 8'h02 : 8'h01, q[7:0])
      `CHK("fast_en", d >= 2, foe)
      `CHK("div_avail", d >= 2, fda)
      `CHK("sub_run", 1'b1, lsr)
      bus(1'b0, SMC_OFF, 8'h00);
      `CHK("div_field", d[2:0], q[7:5])
    end
    bus(1'b1, SMC_OFF, 8'h03);
    wait_ready();
    $display("test divider done");
    // Each halt mode, then wake
    foreach (row[i]) begin
      vde <= row[i][3];
      bus(1'b1, CTRL_OFF, {7'h00, row[i][4]});
      bus(1'b1, SMC_OFF, {6'h00, row[i][5], 1'b1});
      i_scm_cpu_model.do_halt();
      repeat (4) @(posedge core_clk);
      bus(1'b0, MODE_OFF, 8'h00);
      `CHK("halt_mode", row[i][0] ? 8'h10 : (row[i][5] ? (row[i][4] ? 8'h08 : 8'h04) : 8'h20), q[7:0])
      `CHK("cpu_stop", 1'b0, cpu_run)
      `CHK("sub_keep", row[i][2], lsr)
      `CHK("wdt_clk", row[i][2], wcr)
      `CHK("tb_keep", row[i][1], tbr)
      bus(1'b0, SMC_OFF, 8'h00);
      if (row[i][0]) `CHK("wdt_off", 1'b1, wdd)
      if (row[i][0]) `CHK("lrdy_low", 1'b0, q[3])
      if (row[i][4] == 1'b0) `CHK("hrdy_low", 1'b0, q[2])
      i_scm_cpu_model.do_wake();
      wait_ready();
      bus(1'b0, MODE_OFF, 8'h00);
      `CHK("woke", 8'h01, q[7:0])
    end
    $display("test halt modes done");
    // Fast wake with the external fast crystal strap
    vde <= 1'b0;
    cfg_fast <= 1'b1;
    wait_ready();
    bus(1'b1, CTRL_OFF, 8'h00);
    bus(1'b1, SMC_OFF, 8'h13);
    i_scm_cpu_model.do_halt();
    repeat (4) @(posedge core_clk);
    i_scm_cpu_model.do_wake();
    repeat (100) @(posedge core_clk);
    `CHK("fw_run", 1'b1, cpu_run)
    bus(1'b0, SMC_OFF, 8'h00);
    `CHK("fw_hrdy", 1'b0, q[2])
    $display("test fast wake done");
    report_and_stop();
  end
endmodule
`default_nettype wire
